// *** rtl/sync_serial_pkg.sv ***
// package: register map, field positions, reset values and carrier types of the serial unit
package sync_serial_pkg;

  // register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] addr_receive_status_control  = 8'h00;
  localparam logic [7:0] addr_transmit_status_control = 8'h04;
  localparam logic [7:0] addr_baud_control            = 8'h08;
  localparam logic [7:0] addr_baud_divisor_low        = 8'h0c;
  localparam logic [7:0] addr_baud_divisor_high       = 8'h10;
  localparam logic [7:0] addr_receive_data            = 8'h14;
  localparam logic [7:0] addr_transmit_data           = 8'h18;
  localparam logic [7:0] addr_interrupt_control       = 8'h1c;

  // receive_status_control fields
  localparam int rs_port_enable     = 7;
  localparam int rs_nine_bit        = 6;
  localparam int rs_single_enable   = 5;
  localparam int rs_continuous      = 4;
  localparam int rs_overrun         = 1;
  localparam int rs_ninth_bit       = 0;
  // transmit_status_control fields
  localparam int ts_clock_source    = 7;
  localparam int ts_nine_bit        = 6;
  localparam int ts_transmit_enable = 5;
  localparam int ts_sync_mode       = 4;
  localparam int ts_high_speed      = 2;
  localparam int ts_shift_empty     = 1;
  localparam int ts_ninth_bit       = 0;
  // baud_control fields
  localparam int bc_receive_idle    = 6;
  localparam int bc_wide_divisor    = 3;
  // interrupt_control fields
  localparam int ic_global_enable   = 7;
  localparam int ic_peripheral      = 6;
  localparam int ic_receive_enable  = 5;
  localparam int ic_transmit_enable = 4;
  localparam int ic_receive_flag    = 1;
  localparam int ic_transmit_flag   = 0;

  localparam logic [7:0] reset_receive_status_control  = 8'h00;
  localparam logic [7:0] reset_transmit_status_control = 8'h02;
  localparam logic [7:0] reset_baud_control            = 8'h00;
  localparam logic [7:0] reset_interrupt_control       = 8'h00;
  localparam logic [3:0] bits_eight                    = 4'h8;
  localparam logic [3:0] bits_nine                     = 4'h9;
  localparam logic [1:0] axi_okay                      = 2'h0;
  localparam logic [1:0] axi_slverr                    = 2'h2;

  // one received character: ninth bit above the low byte
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } char_type;

  typedef struct packed {
    logic       sck_meta;
    logic       sck_sync;
    logic       sck_prev;
    logic       dat_meta;
    logic       dat_sync;
  } pin_sync_type;

endpackage

// *** rtl/sync_serial_unit.sv ***
// design: synchronous serial unit, master receive and slave transmit/receive, AXI4-Lite registers
`timescale 1ns/10ps

module sync_serial_unit (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial clock pin
  input  wire logic        serial_clock_in,
  output logic             serial_clock_out,
  output logic             serial_clock_oe,
  // serial data pin
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  // core events
  output logic             interrupt_request,
  output logic             wake_request
);

  typedef struct packed {
    logic [7:0]                   receive_status_control;
    logic [7:0]                   transmit_status_control;
    logic [7:0]                   baud_control;
    logic [7:0]                   baud_divisor_low;
    logic [7:0]                   baud_divisor_high;
    logic [7:0]                   interrupt_control;
    sync_serial_pkg::pin_sync_type pins;
    sync_serial_pkg::char_type    fifo_head;
    sync_serial_pkg::char_type    fifo_tail;
    logic [1:0]                   fifo_count;
    logic [8:0]                   receive_shift_register;
    logic [3:0]                   rx_bits;
    logic [8:0]                   transmit_shift_register;
    logic [3:0]                   tx_bits;
    logic                         tsr_busy;
    sync_serial_pkg::char_type    transmit_data;
    logic                         holding_full;
    logic [15:0]                  baud_count;
    logic                         clock_level;
    logic                         aw_taken;
    logic                         w_taken;
    logic [7:0]                   aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic                         irq;
    logic                         wake;
    logic                         data_out;
    logic                         data_oe;
    logic                         clock_oe;
  } state_type;

  state_type state;
  state_type next_state;

  // bit count for one character: nine or eight
  function automatic logic [3:0] char_bits(input logic nine);
    char_bits = nine ? sync_serial_pkg::bits_nine : sync_serial_pkg::bits_eight;
  endfunction

  // byte-lane merge of a register write
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                      input logic [3:0] s);
    lane = s[0] ? d[7:0] : old;
  endfunction

  logic sync_mode;
  logic port_enable;
  logic master;
  logic slave;
  logic single_en;
  logic cont_en;
  logic receiving;
  logic lead_edge;
  logic trail_edge;
  logic master_tick;
  logic master_trail;
  logic master_lead;
  logic shift_trail;
  logic shift_lead;
  logic rx_done;
  logic tx_done;
  logic rd_data;
  logic wr_fire;
  logic receive_flag;
  logic transmit_flag;
  logic [3:0] nbits_rx;
  logic [7:0] rsc_wr;
  logic [7:0] tsc_wr;
  sync_serial_pkg::char_type rx_char;

  always_comb begin
    next_state = state;
    sync_mode  = state.transmit_status_control[sync_serial_pkg::ts_sync_mode];
    port_enable = state.receive_status_control[sync_serial_pkg::rs_port_enable];
    master     = sync_mode && state.transmit_status_control[sync_serial_pkg::ts_clock_source];
    slave      = sync_mode && !state.transmit_status_control[sync_serial_pkg::ts_clock_source];
    single_en  = state.receive_status_control[sync_serial_pkg::rs_single_enable];
    cont_en    = state.receive_status_control[sync_serial_pkg::rs_continuous];
    receiving  = single_en || cont_en;
    nbits_rx   = char_bits(state.receive_status_control[sync_serial_pkg::rs_nine_bit]);
    rsc_wr     = lane(state.receive_status_control, state.w_data, state.w_strb);
    tsc_wr     = lane(state.transmit_status_control, state.w_data, state.w_strb);

    // pin synchronisers: the first stage feeds only the second
    next_state.pins.sck_meta = serial_clock_in;
    next_state.pins.sck_sync = state.pins.sck_meta;
    next_state.pins.sck_prev = state.pins.sck_sync;
    next_state.pins.dat_meta = serial_data_in;
    next_state.pins.dat_sync = state.pins.dat_meta;
    // idle-low clock: rising is leading, falling is trailing
    lead_edge  = state.pins.sck_sync && !state.pins.sck_prev;
    trail_edge = !state.pins.sck_sync && state.pins.sck_prev;

    // master clock generator, half period = divisor + 1 system clocks
    master_tick = 1'b0;
    if (port_enable && master && receiving) begin
      if (state.baud_count == {state.baud_divisor_high, state.baud_divisor_low}) begin
        next_state.baud_count = 16'h0000;
        master_tick = 1'b1;
      end else begin
        next_state.baud_count = state.baud_count + 16'h0001;
      end
    end else begin
      next_state.baud_count = 16'h0000;
    end
    master_lead  = master_tick && !state.clock_level;
    master_trail = master_tick && state.clock_level;
    // overrun holds the clock; partial characters are dropped if enables fall
    if (master_tick && state.receive_status_control[sync_serial_pkg::rs_overrun] == 1'b0) begin
      next_state.clock_level = !state.clock_level;
    end
    if (!(port_enable && master && receiving)) begin
      next_state.clock_level = 1'b0;
    end

    shift_trail = master ? master_trail : (slave && trail_edge);
    shift_lead  = master ? master_lead : (slave && lead_edge);

    // receive shift register, sampling on the trailing edge
    rx_done = 1'b0;
    rx_char = '0;
    if (port_enable && receiving && (master || slave) &&
        !state.receive_status_control[sync_serial_pkg::rs_overrun] && shift_trail) begin
      next_state.receive_shift_register = {state.pins.dat_sync,
                                           state.receive_shift_register[8:1]};
      if (state.rx_bits + 4'h1 == nbits_rx) begin
        next_state.rx_bits = 4'h0;
        rx_done = 1'b1;
        rx_char = nbits_rx == sync_serial_pkg::bits_nine ?
                  {state.pins.dat_sync, state.receive_shift_register[8:1]} :
                  {1'b0, state.pins.dat_sync, state.receive_shift_register[8:2]};
      end else begin
        next_state.rx_bits = state.rx_bits + 4'h1;
      end
    end
    if (!receiving || !port_enable) begin
      next_state.rx_bits = 4'h0;
    end

    // bus handshake
    next_state.aw_taken = state.aw_taken || (s_axi_awvalid && !state.aw_taken);
    next_state.w_taken  = state.w_taken || (s_axi_wvalid && !state.w_taken);
    if (s_axi_awvalid && !state.aw_taken) begin
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_taken) begin
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    wr_fire = state.aw_taken && state.w_taken && !state.bvalid;
    rd_data = s_axi_arvalid && !state.rvalid &&
              s_axi_araddr == sync_serial_pkg::addr_receive_data;

    // two-deep receive buffer; a read pops the head
    if (rd_data && state.fifo_count != 2'h0) begin
      next_state.fifo_head  = state.fifo_tail;
      next_state.fifo_count = state.fifo_count - 2'h1;
    end
    if (rx_done) begin
      if (state.fifo_count == 2'h2 && !rd_data) begin
        next_state.receive_status_control[sync_serial_pkg::rs_overrun] = 1'b1;
      end else if (next_state.fifo_count == 2'h0) begin
        next_state.fifo_head  = rx_char;
        next_state.fifo_count = 2'h1;
      end else begin
        next_state.fifo_tail  = rx_char;
        next_state.fifo_count = next_state.fifo_count + 2'h1;
      end
      if (master && single_en) begin
        next_state.receive_status_control[sync_serial_pkg::rs_single_enable] = 1'b0;
      end
    end
    // single-mode overrun clears on a data read
    if (rd_data && single_en && !cont_en) begin
      next_state.receive_status_control[sync_serial_pkg::rs_overrun] = 1'b0;
    end

    // transmit: holding register to shift register handover
    tx_done = 1'b0;
    if (port_enable && sync_mode && !receiving &&
        state.transmit_status_control[sync_serial_pkg::ts_transmit_enable]) begin
      if (state.tsr_busy && shift_lead) begin
        next_state.data_out = state.transmit_shift_register[0];
        next_state.transmit_shift_register = {1'b0, state.transmit_shift_register[8:1]};
        if (state.tx_bits ==
            char_bits(state.transmit_status_control[sync_serial_pkg::ts_nine_bit]) - 4'h1) begin
          tx_done = 1'b1;
        end
        next_state.tx_bits = state.tx_bits + 4'h1;
      end
      if ((!state.tsr_busy || tx_done) && state.holding_full) begin
        next_state.transmit_shift_register = state.transmit_data;
        next_state.tx_bits      = 4'h0;
        next_state.tsr_busy     = 1'b1;
        next_state.holding_full = 1'b0;
      end else if (tx_done) begin
        next_state.tsr_busy = 1'b0;
      end
      next_state.data_oe = 1'b1;
    end else begin
      next_state.data_oe  = 1'b0;
      next_state.tsr_busy = 1'b0;
      next_state.tx_bits  = 4'h0;
    end
    next_state.clock_oe = port_enable && master;

    // register reads
    if (s_axi_arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = sync_serial_pkg::axi_okay;
      unique case (s_axi_araddr)
        sync_serial_pkg::addr_receive_status_control:
          next_state.rdata = {24'h000000, state.receive_status_control[7:1],
                              state.fifo_head.ninth};
        sync_serial_pkg::addr_transmit_status_control:
          next_state.rdata = {24'h000000, state.transmit_status_control[7:2],
                              !state.tsr_busy, state.transmit_status_control[0]};
        sync_serial_pkg::addr_baud_control:
          next_state.rdata = {24'h000000, state.baud_control[7],
                              !(receiving && state.rx_bits != 4'h0), state.baud_control[5:0]};
        sync_serial_pkg::addr_baud_divisor_low:
          next_state.rdata = {24'h000000, state.baud_divisor_low};
        sync_serial_pkg::addr_baud_divisor_high:
          next_state.rdata = {24'h000000, state.baud_divisor_high};
        sync_serial_pkg::addr_receive_data:
          next_state.rdata = {24'h000000, state.fifo_head.data};
        sync_serial_pkg::addr_interrupt_control:
          next_state.rdata = {24'h000000, state.interrupt_control[7:2],
                              state.fifo_count != 2'h0, !state.holding_full};
        sync_serial_pkg::addr_transmit_data:
          next_state.rdata = 32'h00000000;
        default: begin
          next_state.rdata = 32'h00000000;
          next_state.rresp = sync_serial_pkg::axi_slverr;
        end
      endcase
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // register writes
    if (wr_fire) begin
      next_state.aw_taken = 1'b0;
      next_state.w_taken  = 1'b0;
      next_state.bvalid   = 1'b1;
      next_state.bresp    = sync_serial_pkg::axi_okay;
      unique case (state.aw_addr)
        sync_serial_pkg::addr_receive_status_control: begin
          next_state.receive_status_control[7:2] = rsc_wr[7:2];
          // an overrun raised in this very cycle outlives the clear
          if (state.w_strb[0] && !state.w_data[sync_serial_pkg::rs_continuous] &&
              !(rx_done && state.fifo_count == 2'h2 && !rd_data)) begin
            next_state.receive_status_control[sync_serial_pkg::rs_overrun] = 1'b0;
          end
        end
        sync_serial_pkg::addr_transmit_status_control:
          next_state.transmit_status_control = {tsc_wr[7:2], 1'b0, tsc_wr[0]};
        sync_serial_pkg::addr_baud_control:
          next_state.baud_control = lane(state.baud_control, state.w_data, state.w_strb) &
                                    8'h0c;
        sync_serial_pkg::addr_baud_divisor_low:
          next_state.baud_divisor_low = lane(state.baud_divisor_low, state.w_data, state.w_strb);
        sync_serial_pkg::addr_baud_divisor_high:
          next_state.baud_divisor_high =
            lane(state.baud_divisor_high, state.w_data, state.w_strb);
        sync_serial_pkg::addr_interrupt_control:
          next_state.interrupt_control =
            lane(state.interrupt_control, state.w_data, state.w_strb) & 8'hf0;
        sync_serial_pkg::addr_transmit_data:
          if (state.w_strb[0] && !state.holding_full) begin
            next_state.transmit_data = {
              state.transmit_status_control[sync_serial_pkg::ts_ninth_bit],
              state.w_data[7:0]};
            next_state.holding_full = 1'b1;
          end
        sync_serial_pkg::addr_receive_data: ;
        default: next_state.bresp = sync_serial_pkg::axi_slverr;
      endcase
    end else if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // port disable clears overrun, the receive buffer, the holding register, the shift state and the pin enables
    if (!next_state.receive_status_control[sync_serial_pkg::rs_port_enable]) begin
      next_state.receive_status_control[sync_serial_pkg::rs_overrun] = 1'b0;
      next_state.fifo_count   = 2'h0;
      next_state.holding_full = 1'b0;
      next_state.tsr_busy     = 1'b0;
      next_state.rx_bits      = 4'h0;
      next_state.data_oe      = 1'b0;
      next_state.clock_oe     = 1'b0;
    end

    // flags and interrupt; wake needs only the peripheral enables
    receive_flag  = next_state.fifo_count != 2'h0;
    transmit_flag = !next_state.holding_full;
    next_state.wake = state.interrupt_control[sync_serial_pkg::ic_peripheral] &&
      (receive_flag && state.interrupt_control[sync_serial_pkg::ic_receive_enable] ||
       transmit_flag && state.interrupt_control[sync_serial_pkg::ic_transmit_enable]);
    next_state.irq  = next_state.wake &&
                      state.interrupt_control[sync_serial_pkg::ic_global_enable];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.receive_status_control  <= sync_serial_pkg::reset_receive_status_control;
      state.transmit_status_control <= sync_serial_pkg::reset_transmit_status_control;
      state.baud_control            <= sync_serial_pkg::reset_baud_control;
      state.interrupt_control       <= sync_serial_pkg::reset_interrupt_control;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready     = !state.aw_taken;
  assign s_axi_wready      = !state.w_taken;
  assign s_axi_bvalid      = state.bvalid;
  assign s_axi_bresp       = state.bresp;
  assign s_axi_arready     = !state.rvalid;
  assign s_axi_rvalid      = state.rvalid;
  assign s_axi_rdata       = state.rdata;
  assign s_axi_rresp       = state.rresp;
  assign serial_clock_out  = state.clock_level;
  assign serial_clock_oe   = state.clock_oe;
  assign serial_data_out   = state.data_out;
  assign serial_data_oe    = state.data_oe;
  assign interrupt_request = state.irq;
  assign wake_request      = state.wake;

endmodule

// *** tb/sync_serial_unit_asserts.sv ***
// checker: bus handshakes and event relations at the ports of the serial unit
`timescale 1ns/10ps
module sync_serial_unit_asserts (
  // watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clock_oe,
  input wire logic serial_data_oe,
  input wire logic interrupt_request,
  input wire logic wake_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    && !serial_clock_oe && !serial_data_oe) else $error("outputs busy after reset");
  // irq and wake come from one next-state term, so irq never stands alone
  irq_needs_wake_a: assert property (interrupt_request |-> wake_request)
    else $error("irq without wake");
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  write_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready) else $error("write not released");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
endmodule

bind sync_serial_unit sync_serial_unit_asserts u_sync_serial_unit_asserts (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .serial_clock_oe,
  .serial_data_oe, .interrupt_request, .wake_request);

// *** tb/serial_partner.sv ***
// partner: external synchronous master making the link clock and data
`timescale 1ns/10ps
module serial_partner (
  // link pins
  output logic       serial_clock,
  output logic       serial_data,
  input  wire logic  device_data,
  // word seen on the data line
  output logic [8:0] sampled
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    sampled      = 9'h000;
  end
  // lsb first; the clock stands low outside frames
  task automatic frame(input logic [8:0] word, input int bits, input int half);
    for (int i = 0; i < bits; i++) begin
      #(half);
      serial_clock = 1'b1;
      serial_data  = word[i];
      #(half);
      serial_clock = 1'b0;
      sampled[i]   = device_data;
    end
    #(half);
    // no pull on the line: a released value must not look held
    serial_data = ~serial_data;
  endtask
endmodule

// *** tb/testbench.sv ***
// testbench: register map, slave receive and transmit, master receive
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] a_rsc = sync_serial_pkg::addr_receive_status_control;
  localparam logic [7:0] a_tsc = sync_serial_pkg::addr_transmit_status_control;
  localparam logic [7:0] a_dl  = sync_serial_pkg::addr_baud_divisor_low;
  localparam logic [7:0] a_rd  = sync_serial_pkg::addr_receive_data;
  localparam logic [7:0] a_td  = sync_serial_pkg::addr_transmit_data;
  localparam logic [7:0] a_ic  = sync_serial_pkg::addr_interrupt_control;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, sck, sdat, psck, pdat, ck_out, ck_oe, dt_out, dt_oe;
  logic        irq, wake;
  logic [7:0]  awaddr, araddr, d, d1;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp, rsp;
  logic [8:0]  w [3];
  logic [8:0]  got;
  int          n_errors, compares, n_edges;
  assign sck  = ck_oe ? ck_out : psck;
  assign sdat = dt_oe ? dt_out : pdat;
  sync_serial_unit u_sync_serial_unit (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_clock_in(sck), .serial_clock_out(ck_out),
    .serial_clock_oe(ck_oe), .serial_data_in(sdat), .serial_data_out(dt_out),
    .serial_data_oe(dt_oe), .interrupt_request(irq), .wake_request(wake));
  serial_partner u_serial_partner (.serial_clock(psck), .serial_data(pdat),
    .device_data(sdat), .sampled(got));
  always #10 aclk = ~aclk;
  always @(posedge sck) n_edges++;
  function automatic logic [31:0] status_exp(input logic [7:0] c, input logic o, input logic n);
    return {24'h000000, c[7:2], o, n};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v);
    logic pa, pw, pb;
    pa = 1'b1;
    pw = wr;
    pb = 1'b1;
    @(posedge aclk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= {24'h000000, v};
    awvalid <= wr;
    wvalid  <= wr;
    bready  <= wr;
    arvalid <= !wr;
    rready  <= !wr;
    for (int t = 0; (pa || pw || pb) && t < 200; t++) begin
      @(posedge aclk);
      if (pa && (wr ? awready : arready)) begin
        pa = 1'b0;
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (pb && (wr ? bvalid : rvalid)) begin
        pb = 1'b0;
        bready <= 1'b0;
        rready <= 1'b0;
        q   = rdata;
        rsp = wr ? bresp : rresp;
      end
    end
    if (pa || pw || pb)
      n_errors++;
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'h36118760));
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {n_errors, compares} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    acc(0, a_rsc, 8'h00);
    chk("rsc reset", q, 32'h00000000);
    acc(0, a_tsc, 8'h00);
    chk("tsc reset", q, 32'h00000002);
    acc(0, 8'h20, 8'h00);
    chk("unmapped", 32'(rsp), 32'(sync_serial_pkg::axi_slverr));
    d = 8'($urandom);
    acc(1, a_dl, d);
    chk("write resp", 32'(rsp), 32'(sync_serial_pkg::axi_okay));
    acc(0, a_dl, 8'h00);
    chk("divisor", q, {24'h000000, d});
    // slave receive, nine bits, third frame overruns
    acc(1, a_tsc, 8'h10);
    acc(1, a_ic, 8'h60);
    acc(1, a_rsc, 8'hd0);
    foreach (w[i]) begin
      w[i] = 9'($urandom);
      u_serial_partner.frame(w[i], 9, 80);
      repeat (8) @(posedge aclk);
      chk("wake", 32'(wake), 32'h1);
    end
    chk("clock oe", 32'(ck_oe), 32'h0);
    chk("data oe", 32'(dt_oe), 32'h0);
    chk("irq off", 32'(irq), 32'h0);
    acc(1, a_ic, 8'he0);
    repeat (3) @(posedge aclk);
    chk("irq on", 32'(irq), 32'h1);
    for (int i = 0; i < 2; i++) begin
      acc(0, a_rsc, 8'h00);
      chk("status", q, status_exp(8'hd0, 1'b1, w[i][8]));
      acc(0, a_rd, 8'h00);
      chk("rx char", q, {24'h000000, w[i][7:0]});
    end
    acc(1, a_rsc, 8'hc0);
    acc(0, a_rsc, 8'h00);
    chk("overrun clear", 32'(q[1]), 32'h0);
    acc(1, a_rsc, 8'ha0);
    u_serial_partner.frame(w[2], 8, 80);
    repeat (8) @(posedge aclk);
    acc(0, a_rd, 8'h00);
    chk("single ignored", q, {24'h000000, w[2][7:0]});
    // slave transmit of two queued words
    acc(1, a_rsc, 8'h80);
    acc(1, a_ic, 8'hd0);
    acc(1, a_tsc, 8'h30);
    d  = 8'($urandom);
    d1 = 8'($urandom);
    acc(1, a_td, d);
    acc(1, a_td, d1);
    repeat (4) @(posedge aclk);
    chk("tx oe", 32'(dt_oe), 32'h1);
    chk("ready clear", 32'(wake), 32'h0);
    u_serial_partner.frame(9'h000, 8, 80);
    repeat (8) @(posedge aclk);
    chk("first out", 32'(got[7:0]), 32'(d));
    chk("ready irq", 32'(irq), 32'h1);
    u_serial_partner.frame(9'h000, 8, 80);
    chk("second out", 32'(got[7:0]), 32'(d1));
    acc(1, a_rsc, 8'h00);
    repeat (3) @(posedge aclk);
    chk("port off", 32'(dt_oe), 32'h0);
    // master single receive
    acc(1, a_dl, 8'h01);
    acc(1, a_tsc, 8'h90);
    acc(1, a_rsc, 8'h80);
    n_edges = 0;
    acc(1, a_rsc, 8'ha0);
    q = 32'h00000020;
    for (int t = 0; t < 40 && q[5] === 1'b1; t++)
      acc(0, a_rsc, 8'h00);
    chk("single clear", 32'(q[5]), 32'h0);
    chk("clock count", n_edges, 32'h8);
    chk("master oe", 32'(ck_oe), 32'h1);
    acc(0, a_rd, 8'h00);
    chk("master char", q, {24'h000000, {8{pdat}}});
    give_verdict;
  end
endmodule
